// ### tb/rre_exec_asserts.sv
// timing checker for the return and rotate execution block
`timescale 1ns/100ps
`default_nettype none
module rre_exec_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0] reg_rdata,
    input wire logic busy,
    input wire logic stack_pop,
    input wire logic pc_load,
    input wire logic carry_out,
    input wire logic carry_we,
    input wire logic reg_we,
    input wire logic [6:0] reg_waddr,
    input wire logic [7:0] w_out,
    input wire logic done
);
    // ----------------
    // take and checks
    // ----------------
    wire tk = ce && instr_valid && !busy;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    a_ret_pop:
        assert property (tk && instr == 14'h0008 |=> stack_pop && pc_load && busy)
        else $error("return did not pop");
    a_ret_done:
        assert property (busy && ce |=> done && !busy) else $error("return overran");
    a_lit_w:
        assert property (tk && instr[13:8] == 6'h34 |=> w_out == $past(instr[7:0]) && stack_pop)
        else $error("literal return wrong");
    a_rotl_c:
        assert property (tk && instr[13:8] == 6'h0D |=> carry_out == $past(reg_rdata[7])
            && carry_we && done) else $error("rotate left carry wrong");
    a_rotr_c:
        assert property (tk && instr[13:8] == 6'h0C |=> carry_out == $past(reg_rdata[0])
            && carry_we && done) else $error("rotate right carry wrong");
    a_rot_dest:
        assert property (tk && instr[13:9] == 5'h06 |=> reg_we == $past(instr[7])
            && reg_waddr == $past(instr[6:0])) else $error("rotate target wrong");
    a_ret_flags:
        assert property (stack_pop |-> !carry_we && !reg_we) else $error("return wrote flag");
    a_pop_once:
        assert property (stack_pop && ce |=> !stack_pop && !pc_load) else $error("pop too long");
    cover property (tk && instr == 14'h0008);
    cover property (tk && instr[13:8] == 6'h34);
    cover property (tk && instr[13:9] == 5'h06 && instr[7]);
    cover property (busy && !ce);
endmodule
bind rre_exec rre_exec_chk u_chk (.clock, .rstn, .ce, .instr_valid, .instr, .reg_rdata, .busy,
    .stack_pop, .pc_load, .carry_out, .carry_we, .reg_we, .reg_waddr, .w_out, .done);
`default_nettype wire

// ### tb/tb_top.sv
// random bench for the return and rotate execution block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clock, rstn, ce, instr_valid, busy, stack_pop, pc_load, done;
    logic carry_out, carry_we, reg_we, c, d;
    logic [13:0] instr;
    logic [10:0] stack_top_entry, pc_value;
    logic [7:0] reg_rdata, w_out, reg_wdata, w, res, dat;
    logic [6:0] reg_waddr;
    int seed = 75, fail_count = 0, n_compared = 0, kind;
    rre_exec u_dut (.clock, .rstn, .ce, .instr_valid, .instr, .stack_top_entry, .reg_rdata,
        .busy, .stack_pop, .pc_load, .pc_value, .w_out, .carry_out, .carry_we, .reg_we,
        .reg_waddr, .reg_wdata, .done);
    // ---------------
    // clock and tasks
    // ---------------
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // expected {carry, result} of a rotate through carry
    function automatic logic [8:0] rot_exp(input logic lft, input logic [7:0] v, input logic ci);
        return lft ? {v, ci} : {v[0], ci, v[7:1]};
    endfunction
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        #20000;
        fail_count++;
        tally_and_finish;
    end
    // first op is a fixed rotate left, then random mix held back to back
    initial
    begin
        {rstn, ce, instr_valid} = 3'b010;
        instr = 14'h0000;
        stack_top_entry = 11'h000;
        reg_rdata = 8'h00;
        w = 8'h00;
        c = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        for (int i = 0; i < 300; i++)
        begin
            kind = (i == 0) ? 0 : {$random(seed)} % 5;
            dat = (i == 0) ? 8'hE6 : 8'($random(seed));
            d = (i == 0) ? 1'b0 : 1'($random(seed));
            stack_top_entry = 11'($random(seed));
            reg_rdata = dat;
            instr_valid = 1'b1;
            case (kind)
                0, 1: instr = {5'h06, ~kind[0], d, 7'($random(seed))};
                2: instr = 14'h0008;
                3: instr = {6'h34, dat};
                default: instr = 14'h0000;
            endcase
            @(negedge clock);
            if (kind < 2)
            begin
                {c, res} = rot_exp(kind == 0, dat, c);
                w = d ? w : res;
                chk({done, carry_we, reg_we, stack_pop}, {2'h3, d, 1'b0});
                chk(reg_waddr, instr[6:0]);
                chk({reg_wdata, carry_out, w_out}, {res, c, w});
            end
            else if (kind < 4)
            begin
                w = (kind == 3) ? dat : w;
                chk({stack_pop, pc_load, busy, done, carry_we}, 5'h1C);
                chk(pc_value, stack_top_entry);
                chk({w_out, carry_out}, {w, c});
                @(negedge clock);
                chk({stack_pop, busy, done, carry_we}, 4'h2);
            end
        end
        // idle cycle, then clock enable low freezes a rotate and a return's second cycle
        instr_valid = 1'b0;
        @(negedge clock);
        chk({done, stack_pop, carry_we, reg_we}, 4'h0);
        ce = 1'b0;
        instr_valid = 1'b1;
        dat = 8'h81;
        reg_rdata = dat;
        instr = {6'h0D, 1'b0, 7'h7F};
        @(negedge clock);
        chk({done, carry_we, w_out, carry_out}, {2'h0, w, c});
        ce = 1'b1;
        @(negedge clock);
        {c, res} = rot_exp(1'b1, dat, c);
        w = res;
        chk({done, w_out, carry_out, reg_waddr}, {1'b1, w, c, 7'h7F});
        instr = 14'h0008;
        stack_top_entry = 11'h7FF;
        @(negedge clock);
        ce = 1'b0;
        @(negedge clock);
        chk({stack_pop, pc_load, busy, done}, 4'hE);
        ce = 1'b1;
        @(negedge clock);
        chk({stack_pop, busy, done, pc_value}, {3'h1, 11'h7FF});
        tally_and_finish;
    end
endmodule
`default_nettype wire

// ### verilog/rre_decode.sv
// instruction word decoder for return and rotate operations
`timescale 1ns/100ps
`default_nettype none
`include "rre_map.svh"
module rre_decode #(
    parameter int IW = 14
) (
    input wire logic [IW-1:0] instr,
    output var rre_pkg::rre_op_type op,
    output logic [7:0] literal,
    output logic [6:0] reg_addr,
    output logic dest_sel
);
    // ----------------------------------------
    // field extraction
    // ----------------------------------------
    assign literal = instr[`RRE_LIT_MSB:0];
    assign reg_addr = instr[`RRE_ADDR_MSB:0];
    assign dest_sel = instr[`RRE_DEST_BIT];
    // opcode match
    always_comb
    begin
        op = rre_pkg::RRE_OP_NONE;
        if (instr == `RRE_OPC_RETURN)
            op = rre_pkg::RRE_OP_RETURN;
        else if (instr[`RRE_OP_MSB:`RRE_OP_LSB] == `RRE_OPC_LITRET_HI)
            op = rre_pkg::RRE_OP_LITRET;
        else if (instr[`RRE_OP_MSB:`RRE_OP_LSB] == `RRE_OPC_ROTL_HI)
            op = rre_pkg::RRE_OP_ROTL;
        else if (instr[`RRE_OP_MSB:`RRE_OP_LSB] == `RRE_OPC_ROTR_HI)
            op = rre_pkg::RRE_OP_ROTR;
    end
endmodule
`default_nettype wire

// ### verilog/rre_exec.sv
// execution of return, literal return and rotate-through-carry
`timescale 1ns/100ps
`default_nettype none
`include "rre_map.svh"
// Notes on behaviour
// - a plain return pops the stack into the program counter, touches no flag, takes two cycles.
// - a literal return loads its 8-bit immediate into the working register, flags untouched, two cycles.
// - a literal return also pops the stack and loads the saved address into the program counter.
// - rotate left moves old carry into bit 0 and old bit 7 into carry.
// - rotate right moves old carry into bit 7 and old bit 0 into carry.
// - rotate result goes to the working register when destination is 0, else back to the register.
// - rotates decode a 7-bit register address and a one-bit destination select.
module rre_exec #(
    parameter int PCW = 11,
    parameter int IW = 14
) (
    // clock, reset and enable
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    // instruction word and the operands it reads
    input wire logic instr_valid,
    input wire logic [IW-1:0] instr,
    input wire logic [PCW-1:0] stack_top_entry,
    input wire logic [7:0] reg_rdata,
    // return sequencing towards the stack and program counter
    output logic busy,
    output logic stack_pop,
    output logic pc_load,
    output logic [PCW-1:0] pc_value,
    // working register, carry and register write port
    output logic [7:0] w_out,
    output logic carry_out,
    output logic carry_we,
    output logic reg_we,
    output logic [6:0] reg_waddr,
    output logic [7:0] reg_wdata,
    // completion strobe
    output logic done
);
    // ----------------------------------------
    // internal signals
    // ----------------------------------------
    rre_pkg::rre_op_type op;
    rre_pkg::rre_state_type state_r;
    logic [7:0] literal;
    logic [6:0] addr;
    logic dest;
    logic [7:0] rot_res;
    logic rot_c;
    logic take;
    logic [7:0] rot_left;
    logic [7:0] rot_right;
    logic rot_right_sel;
    logic is_ret;
    logic is_rot;
    logic take_ret;
    logic take_lit;
    logic take_rot;
    // ----------------------------------------
    // decoder
    // ----------------------------------------
    rre_decode #(.IW(IW)) u_dec (
        .instr(instr),
        .op(op),
        .literal(literal),
        .reg_addr(addr),
        .dest_sel(dest)
    );
    // instruction accepted only when enabled and not in a return's second cycle
    assign take = ce && instr_valid && state_r == rre_pkg::RRE_ST_IDLE;
    // ----------------------------------------
    // operation classes
    // ----------------------------------------
    // both returns share the pop, the program counter load and the second cycle
    assign is_ret = op == rre_pkg::RRE_OP_RETURN || op == rre_pkg::RRE_OP_LITRET;
    // both rotates share the carry update and the write-back
    assign is_rot = op == rre_pkg::RRE_OP_ROTL || op == rre_pkg::RRE_OP_ROTR;
    assign rot_right_sel = op == rre_pkg::RRE_OP_ROTR;
    // qualified with take so a refused word starts nothing
    assign take_ret = take && is_ret;
    assign take_lit = take && op == rre_pkg::RRE_OP_LITRET;
    assign take_rot = take && is_rot;
    // ----------------------------------------
    // rotate datapath, one slice per bit
    // ----------------------------------------
    // the vacated end of either rotate takes the old carry
    for (genvar gi = 0; gi <= `RRE_DATA_MSB; gi++)
    begin : g_rot_bit
        if (gi == 0)
        begin : g_left_end
            assign rot_left[gi] = carry_out;
        end
        else
        begin : g_left_mid
            assign rot_left[gi] = reg_rdata[gi - 1];
        end
        if (gi == `RRE_DATA_MSB)
        begin : g_right_end
            assign rot_right[gi] = carry_out;
        end
        else
        begin : g_right_mid
            assign rot_right[gi] = reg_rdata[gi + 1];
        end
    end
    // direction select; the bit pushed out becomes the new carry
    assign rot_res = rot_right_sel ? rot_right : rot_left;
    assign rot_c = rot_right_sel ? reg_rdata[0] : reg_rdata[`RRE_DATA_MSB];
    // ----------------------------------------
    // sequencer: returns hold a second cycle
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state_r <= rre_pkg::RRE_ST_IDLE;
        else if (ce)
        begin
            case (state_r)
                rre_pkg::RRE_ST_IDLE:
                    if (take_ret)
                        state_r <= rre_pkg::RRE_ST_RET;
                rre_pkg::RRE_ST_RET:
                    state_r <= rre_pkg::RRE_ST_IDLE;
                default:
                    state_r <= rre_pkg::RRE_ST_IDLE;
            endcase
        end
    end
    // ----------------------------------------
    // busy flag for second cycle of a return
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            busy <= 1'b0;
        else if (ce)
            busy <= take_ret;
    end
    // ----------------------------------------
    // stack pop and program counter load in second cycle, alongside busy
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            stack_pop <= 1'b0;
            pc_load <= 1'b0;
            pc_value <= '0;
        end
        else if (ce)
        begin
            stack_pop <= take_ret;
            pc_load <= take_ret;
            if (take_ret)
                pc_value <= stack_top_entry;
        end
    end
    // ----------------------------------------
    // working register
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            w_out <= `RRE_W_RESET;
        else if (ce && take)
        begin
            if (take_lit)
                w_out <= literal;
            else if ((op == rre_pkg::RRE_OP_ROTL || op == rre_pkg::RRE_OP_ROTR) && !dest)
                w_out <= rot_res;
        end
    end
    // ----------------------------------------
    // carry flag, the only flag rotates touch
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            carry_out <= `RRE_C_RESET;
            carry_we <= 1'b0;
        end
        else if (ce)
        begin
            carry_we <= take_rot;
            if (take_rot)
                carry_out <= rot_c;
        end
    end
    // ----------------------------------------
    // register write-back
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_we <= 1'b0;
            reg_waddr <= '0;
            reg_wdata <= '0;
        end
        else if (ce)
        begin
            reg_we <= take_rot && dest;
            if (take)
            begin
                reg_waddr <= addr;
                reg_wdata <= rot_res;
            end
        end
    end
    // ----------------------------------------
    // completion strobe: rotates at once, returns after second cycle
    // ----------------------------------------
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            done <= 1'b0;
        else if (ce)
            done <= (take && !is_ret)
                || state_r == rre_pkg::RRE_ST_RET;
    end
endmodule
`default_nettype wire

// ### verilog/rre_map.svh
// constants for the return and rotate execution block
`ifndef RRE_MAP_SVH
`define RRE_MAP_SVH
`define RRE_OPC_RETURN 14'h0008
`define RRE_OPC_LITRET_HI 6'h34
`define RRE_OPC_ROTL_HI 6'h0D
`define RRE_OPC_ROTR_HI 6'h0C
`define RRE_LIT_MSB 7
`define RRE_DATA_MSB 7
`define RRE_DEST_BIT 7
`define RRE_ADDR_MSB 6
`define RRE_OP_MSB 13
`define RRE_OP_LSB 8
`define RRE_RET_CYCLES 2'h2
`define RRE_RET_WAIT_INIT 2'h1
`define RRE_W_RESET 8'h00
`define RRE_C_RESET 1'b0
`endif

// ### verilog/rre_pkg.sv
// types for the return and rotate execution block
`default_nettype none
package rre_pkg;
    typedef enum logic [2:0]
    {
        RRE_OP_NONE = 3'b000,
        RRE_OP_RETURN = 3'b001,
        RRE_OP_LITRET = 3'b010,
        RRE_OP_ROTL = 3'b011,
        RRE_OP_ROTR = 3'b100
    } rre_op_type;
    typedef enum logic [1:0]
    {
        RRE_ST_IDLE = 2'b00,
        RRE_ST_RET = 2'b01
    } rre_state_type;
endpackage
`default_nettype wire
